// file: exchange_and_xor_instr_exec.v
/*
 * Decode and execute sequencer for the byte exchange, digit exchange and
 * exclusive OR instructions of an 8-bit core.
 * Assumes the fetch unit presents the opcode with its following bytes at once,
 * and that the RAM/SFR read port answers combinationally in the cycle in which
 * the read request is high.
 */
`timescale 1ns/10ps
`default_nettype none
`include "xch_xor_regs.vh"

// Function
// - Exchange loads accumulator, stores old accumulator
// - Register exchange opcode 11001rrr, one byte
// - Exchange operand register, direct or indirect
// - Indirect exchange opcode 1100011i, one byte
// - Digit exchange swaps low nibbles
// - Digit exchange keeps high nibbles, flags
// - Digit exchange opcode 1101011i, one byte
// - XOR writes destination, flags untouched
// - Six XOR source and destination pairings
// - Port destination read from output latch
// - Direct XOR inverts bits set in mask
// - XOR register opcode 01101rrr, one byte
module exchange_and_xor_instr_exec (
  input wire clk_i,
  input wire reset_n_i,
  input wire instr_valid_i,
  input wire [7:0] opcode_i,
  input wire [7:0] operand1_i,
  input wire [7:0] operand2_i,
  input wire [7:0] acc_i,
  input wire [1:0] bank_sel_i,
  input wire [7:0] rd_data_i,
  output reg instr_ready_o,
  output reg unsupported_o,
  output reg done_o,
  output reg rd_req_o,
  output reg [7:0] rd_addr_o,
  output reg rd_indirect_o,
  output reg rd_latch_o,
  output reg wr_en_o,
  output reg [7:0] wr_addr_o,
  output reg wr_indirect_o,
  output reg [7:0] wr_data_o,
  output reg acc_we_o,
  output reg [7:0] acc_data_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers, used for acceptance and for operand routing.

  function [2:0] op_class;
    input [7:0] op;
    begin
      if (op[7:3] == `OPC_XCH_RN_HI5) begin
        op_class = `CLS_XCH;
      end else if (op == `OPC_XCH_DIR) begin
        op_class = `CLS_XCH;
      end else if (op[7:1] == `OPC_XCH_IND_HI7) begin
        op_class = `CLS_XCH;
      end else if (op[7:1] == `OPC_DIGIT_EXCHANGE_OP_IND_HI7) begin
        op_class = `CLS_DIGIT_EXCHANGE_OP;
      end else if (op[7:3] == `OPC_XRL_RN_HI5) begin
        op_class = `CLS_XRL_ACC;
      end else if (op == `OPC_XRL_A_DIR || op[7:1] == `OPC_XRL_A_IND_HI7 || op == `OPC_XRL_A_IMM) begin
        op_class = `CLS_XRL_ACC;
      end else if (op == `OPC_XRL_DIR_A || op == `OPC_XRL_DIR_IMM) begin
        op_class = `CLS_XRL_DIR;
      end else begin
        op_class = `CLS_NONE;
      end
    end
  endfunction

  function [1:0] src_kind;
    input [7:0] op;
    begin
      if (op[7:3] == `OPC_XCH_RN_HI5 || op[7:3] == `OPC_XRL_RN_HI5) begin
        src_kind = `SRC_REG;
      end else if (op[7:1] == `OPC_XCH_IND_HI7 || op[7:1] == `OPC_DIGIT_EXCHANGE_OP_IND_HI7 ||
                   op[7:1] == `OPC_XRL_A_IND_HI7) begin
        src_kind = `SRC_IND;
      end else if (op == `OPC_XRL_A_IMM) begin
        src_kind = `SRC_IMM;
      end else begin
        src_kind = `SRC_DIR;
      end
    end
  endfunction

  // Bank registers live in the lowest 32 bytes of internal RAM, eight per bank.
  function [7:0] bank_addr;
    input [1:0] bank;
    input [2:0] index;
    begin
      bank_addr = {3'h0, bank, index};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Instruction context held for the length of one execution.

  reg [2:0] state;
  reg [2:0] cls;
  reg [7:0] opnd_addr;
  reg opnd_indirect;
  reg [7:0] opnd;
  reg [7:0] mask;
  reg [7:0] acc_snap;

  wire [2:0] dec_class;
  wire [1:0] dec_src;
  wire [7:0] acc_new;
  wire [7:0] mem_new;
  wire acc_wr;
  wire mem_wr;

  assign dec_class = op_class(opcode_i);
  assign dec_src = src_kind(opcode_i);

  xch_xor_datapath u_datapath (
    .op_class_i(cls),
    .acc_i(acc_snap),
    .opnd_i(opnd),
    .mask_i(mask),
    .acc_new_o(acc_new),
    .mem_new_o(mem_new),
    .acc_wr_o(acc_wr),
    .mem_wr_o(mem_wr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer.
  // The accumulator is sampled once at acceptance; both halves of an exchange
  // then come from that one snapshot, so the swap cannot see its own write.

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= `ST_IDLE;
      cls <= `CLS_NONE;
      opnd_addr <= `RST_BYTE;
      opnd_indirect <= 1'b0;
      opnd <= `RST_BYTE;
      mask <= `RST_BYTE;
      acc_snap <= `RST_BYTE;
      instr_ready_o <= 1'b1;
      unsupported_o <= 1'b0;
      done_o <= 1'b0;
      rd_req_o <= 1'b0;
      rd_addr_o <= `RST_BYTE;
      rd_indirect_o <= 1'b0;
      rd_latch_o <= 1'b0;
      wr_en_o <= 1'b0;
      wr_addr_o <= `RST_BYTE;
      wr_indirect_o <= 1'b0;
      wr_data_o <= `RST_BYTE;
      acc_we_o <= 1'b0;
      acc_data_o <= `RST_BYTE;
    end else begin
      unsupported_o <= 1'b0;
      done_o <= 1'b0;
      wr_en_o <= 1'b0;
      acc_we_o <= 1'b0;
      case (state)
        `ST_IDLE: begin
          if (instr_valid_i && dec_class == `CLS_NONE) begin
            unsupported_o <= 1'b1;
          end else if (instr_valid_i) begin
            cls <= dec_class;
            acc_snap <= acc_i;
            instr_ready_o <= 1'b0;
            // Direct destination takes the mask from the immediate byte or
            // from the accumulator's present value.
            mask <= (opcode_i == `OPC_XRL_DIR_IMM) ? operand2_i : acc_i;
            case (dec_src)
              `SRC_REG: begin
                opnd_addr <= bank_addr(bank_sel_i, opcode_i[`FLD_RRR_MSB:`FLD_RRR_LSB]);
                opnd_indirect <= 1'b0;
                rd_req_o <= 1'b1;
                rd_addr_o <= bank_addr(bank_sel_i, opcode_i[`FLD_RRR_MSB:`FLD_RRR_LSB]);
                rd_indirect_o <= 1'b0;
                rd_latch_o <= 1'b0;
                state <= `ST_OPND;
              end
              `SRC_IND: begin
                // First fetch the pointer register itself.
                opnd_indirect <= 1'b1;
                rd_req_o <= 1'b1;
                rd_addr_o <= bank_addr(bank_sel_i, {2'h0, opcode_i[`FLD_PTR_BIT]});
                rd_indirect_o <= 1'b0;
                rd_latch_o <= 1'b0;
                state <= `ST_PTR;
              end
              `SRC_IMM: begin
                opnd <= operand1_i;
                rd_req_o <= 1'b0;
                state <= `ST_EXEC;
              end
              default: begin
                opnd_addr <= operand1_i;
                opnd_indirect <= 1'b0;
                rd_req_o <= 1'b1;
                rd_addr_o <= operand1_i;
                rd_indirect_o <= 1'b0;
                // A read for a read-modify-write of a direct byte must see the
                // port output latch, not the pins, or pin loading corrupts bits.
                rd_latch_o <= (dec_class == `CLS_XRL_DIR);
                state <= `ST_OPND;
              end
            endcase
          end
        end
        `ST_PTR: begin
          opnd_addr <= rd_data_i;
          rd_addr_o <= rd_data_i;
          rd_indirect_o <= 1'b1;
          rd_latch_o <= 1'b0;
          state <= `ST_OPND;
        end
        `ST_OPND: begin
          opnd <= rd_data_i;
          rd_req_o <= 1'b0;
          rd_indirect_o <= 1'b0;
          rd_latch_o <= 1'b0;
          state <= `ST_EXEC;
        end
        `ST_EXEC: begin
          // Both writes leave in the same cycle; no flag output exists, so
          // status flags are never touched by this slice.
          acc_we_o <= acc_wr;
          acc_data_o <= acc_new;
          wr_en_o <= mem_wr;
          wr_addr_o <= opnd_addr;
          wr_indirect_o <= opnd_indirect;
          wr_data_o <= mem_new;
          done_o <= 1'b1;
          instr_ready_o <= 1'b1;
          state <= `ST_IDLE;
        end
        default: begin
          rd_req_o <= 1'b0;
          instr_ready_o <= 1'b1;
          state <= `ST_IDLE;
        end
      endcase
    end
  end

endmodule // exchange_and_xor_instr_exec
`default_nettype wire

// file: xch_xor_regs.vh
/*
 * Constants for the byte exchange, digit exchange and exclusive OR slice:
 * opcode values, opcode field positions, operation classes and sequencer states.
 * Assumes it is included by bare name from the design files of this slice only.
 */
`ifndef XCH_XOR_REGS_VH
`define XCH_XOR_REGS_VH

// Opcode patterns; the register forms compare the top five bits only.
`define OPC_XCH_RN_HI5 5'h19
`define OPC_XRL_RN_HI5 5'h0D
`define OPC_XCH_DIR 8'hC5
`define OPC_XCH_IND_HI7 7'h63
`define OPC_DIGIT_EXCHANGE_OP_IND_HI7 7'h6B
`define OPC_XRL_A_DIR 8'h65
`define OPC_XRL_A_IND_HI7 7'h33
`define OPC_XRL_A_IMM 8'h64
`define OPC_XRL_DIR_A 8'h62
`define OPC_XRL_DIR_IMM 8'h63

// Field positions inside the opcode byte.
`define FLD_RRR_MSB 2
`define FLD_RRR_LSB 0
`define FLD_PTR_BIT 0

// Operation classes handed to the datapath.
`define CLS_NONE 3'h0
`define CLS_XCH 3'h1
`define CLS_DIGIT_EXCHANGE_OP 3'h2
`define CLS_XRL_ACC 3'h3
`define CLS_XRL_DIR 3'h4

// Source operand kinds.
`define SRC_REG 2'h0
`define SRC_DIR 2'h1
`define SRC_IND 2'h2
`define SRC_IMM 2'h3

// Sequencer states.
`define ST_IDLE 3'h0
`define ST_PTR 3'h1
`define ST_OPND 3'h2
`define ST_EXEC 3'h3

// Reset values.
`define RST_BYTE 8'h00

`endif

// file: xch_xor_datapath.v
/*
 * Combinational result logic for the exchange and exclusive OR slice.
 * Assumes the caller supplies the accumulator, the fetched operand and the mask.
 */
`timescale 1ns/10ps
`default_nettype none
`include "xch_xor_regs.vh"

module xch_xor_datapath (
  input wire [2:0] op_class_i,
  input wire [7:0] acc_i,
  input wire [7:0] opnd_i,
  input wire [7:0] mask_i,
  output reg [7:0] acc_new_o,
  output reg [7:0] mem_new_o,
  output reg acc_wr_o,
  output reg mem_wr_o
);

  always @* begin
    acc_new_o = acc_i;
    mem_new_o = opnd_i;
    acc_wr_o = 1'b0;
    mem_wr_o = 1'b0;
    case (op_class_i)
      `CLS_XCH: begin
        acc_new_o = opnd_i;
        mem_new_o = acc_i;
        acc_wr_o = 1'b1;
        mem_wr_o = 1'b1;
      end
      `CLS_DIGIT_EXCHANGE_OP: begin
        acc_new_o = {acc_i[7:4], opnd_i[3:0]};
        mem_new_o = {opnd_i[7:4], acc_i[3:0]};
        acc_wr_o = 1'b1;
        mem_wr_o = 1'b1;
      end
      `CLS_XRL_ACC: begin
        acc_new_o = acc_i ^ opnd_i;
        acc_wr_o = 1'b1;
      end
      `CLS_XRL_DIR: begin
        mem_new_o = opnd_i ^ mask_i;
        mem_wr_o = 1'b1;
      end
      default: begin
        acc_new_o = acc_i;
      end
    endcase
  end

endmodule // xch_xor_datapath
`default_nettype wire

// file: xch_xor_properties.sv
/* Port checker for the exchange and exclusive OR sequencer.
   Assumes it is bound to exchange_and_xor_instr_exec, one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module xch_xor_checker (
  input wire logic clk_i, reset_n_i, instr_valid_i, instr_ready_o, done_o,
  input wire logic rd_req_o, rd_indirect_o, rd_latch_o, wr_en_o, wr_indirect_o, acc_we_o,
  input wire logic [1:0] bank_sel_i,
  input wire logic [7:0] opcode_i, operand1_i, operand2_i, acc_i, rd_data_i, rd_addr_o, wr_data_o, acc_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic tk = instr_valid_i && instr_ready_o;
  sequence s_rdir; rd_req_o && !rd_indirect_o; endsequence
  sequence s_fin; done_o && instr_ready_o; endsequence
  property p_imm; tk && opcode_i == 8'h64 |=> !instr_ready_o ##1 s_fin ##0 acc_we_o && !wr_en_o
    && acc_data_o == $past(acc_i ^ operand1_i, 2); endproperty
  a_imm: assert property (p_imm) else $error("immediate xor wrong");
  property p_xch_rn; tk && opcode_i[7:3] == 5'h19 |=> s_rdir ##0 rd_addr_o == {3'h0, $past(bank_sel_i),
    $past(opcode_i[2:0])} ##2 s_fin ##0 wr_en_o && acc_we_o && wr_data_o == $past(acc_i, 3); endproperty
  a_xch_rn: assert property (p_xch_rn) else $error("register exchange wrong");
  property p_xrl_rn; tk && opcode_i[7:3] == 5'h0D |=> s_rdir ##2 s_fin ##0 acc_we_o && !wr_en_o
    && acc_data_o == ($past(acc_i, 3) ^ $past(rd_data_i, 2)); endproperty
  a_xrl_rn: assert property (p_xrl_rn) else $error("register xor wrong");
  property p_ind; tk && opcode_i[7:1] == 7'h63 |=> s_rdir ##0 rd_addr_o == {3'h0, $past(bank_sel_i), 2'h0,
    $past(opcode_i[0])} ##1 rd_req_o && rd_indirect_o && rd_addr_o == $past(rd_data_i)
    ##2 s_fin ##0 wr_indirect_o && wr_data_o == $past(acc_i, 4); endproperty
  a_ind: assert property (p_ind) else $error("indirect exchange wrong");
  property p_digit_exchange_op; tk && opcode_i[7:1] == 7'h6B |-> ##4 s_fin ##0 acc_data_o == {$past(acc_i[7:4], 4),
    $past(rd_data_i[3:0], 2)} && wr_data_o == {$past(rd_data_i[7:4], 2), $past(acc_i[3:0], 4)}; endproperty
  a_digit_exchange_op: assert property (p_digit_exchange_op) else $error("digit exchange wrong");
  property p_latch; tk && opcode_i[7:1] == 7'h31 |=> rd_req_o && rd_latch_o
    && rd_addr_o == $past(operand1_i); endproperty
  a_latch: assert property (p_latch) else $error("latch not read");
  property p_mask; tk && opcode_i == 8'h63 |-> ##3 s_fin ##0 wr_en_o
    && wr_data_o == ($past(rd_data_i, 2) ^ $past(operand2_i, 3)); endproperty
  a_mask: assert property (p_mask) else $error("mask xor wrong");
  property p_xch_dir; tk && opcode_i == 8'hC5 |=> s_rdir ##0 !rd_latch_o ##2 s_fin ##0
    acc_data_o == $past(rd_data_i, 2) && wr_data_o == $past(acc_i, 3); endproperty
  a_xch_dir: assert property (p_xch_dir) else $error("direct exchange wrong");
endmodule // xch_xor_checker
bind exchange_and_xor_instr_exec xch_xor_checker xch_xor_checker_inst (.clk_i, .reset_n_i, .instr_valid_i,
  .instr_ready_o, .done_o, .rd_req_o, .rd_indirect_o, .rd_latch_o, .wr_en_o, .wr_indirect_o, .acc_we_o,
  .bank_sel_i, .opcode_i, .operand1_i, .operand2_i, .acc_i, .rd_data_i, .rd_addr_o, .wr_data_o, .acc_data_o);
`default_nettype wire

// file: xch_xor_mem_model.sv
/* Internal RAM and special function register model with one output port.
   Assumes reads are answered combinationally and writes land at the clock edge. */
`timescale 1ns/10ps
`default_nettype none
module xch_xor_mem_model (
  input wire logic clk_i, rd_req_i, rd_ind_i, rd_latch_i, wr_en_i, wr_ind_i,
  input wire logic [7:0] rd_addr_i, wr_addr_i, wr_data_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] ram [0:255];
  logic [7:0] sfr [128:255];
  logic [7:0] last = 8'h00;
  // The port pins read the inverse of the latch so a wrong source shows up.
  function automatic logic [7:0] peek(input logic [7:0] a, input logic ind, latch);
    if (ind || !a[7]) return ram[a];
    return (a == 8'h90 && !latch) ? ~sfr[a] : sfr[a];
  endfunction
  initial begin
    for (int i = 0; i < 256; i++) begin
      ram[i] = 8'(i * 37 + 5);
      if (i > 127) sfr[i] = 8'(i * 11);
    end
  end
  // An idle bus shows the inverse of the last answer, never a stale value.
  always_comb rd_data_o = rd_req_i ? peek(rd_addr_i, rd_ind_i, rd_latch_i) : ~last;
  always @(posedge clk_i) begin
    if (rd_req_i) last <= rd_data_o;
    if (wr_en_i && (wr_ind_i || !wr_addr_i[7])) ram[wr_addr_i] <= wr_data_i;
    else if (wr_en_i) sfr[wr_addr_i] <= wr_data_i;
  end
endmodule // xch_xor_mem_model
`default_nettype wire

// file: exchange_and_xor_instr_exec_test.sv
/* Self-checking bench for the exchange and exclusive OR sequencer.
   Assumes the memory model and the bound checker are compiled with it. */
`timescale 1ns/10ps
`default_nettype none
module exchange_and_xor_instr_exec_test;
  logic clk_i = 0, reset_n_i = 0, instr_valid_i = 0;
  logic [7:0] opcode_i = 0, operand1_i = 0, operand2_i = 0, acc_i = 0;
  logic [1:0] bank_sel_i = 0;
  wire [7:0] rd_data_i, rd_addr_o, wr_addr_o, wr_data_o, acc_data_o;
  wire instr_ready_o, unsupported_o, done_o, rd_req_o, rd_indirect_o, rd_latch_o, wr_en_o, wr_indirect_o, acc_we_o;
  int n_fail = 0, check_count = 0;
  logic [31:0] rnd = 32'd91393;
  logic [7:0] ops [10] = '{8'hC8, 8'hC5, 8'hC6, 8'hD6, 8'h68, 8'h65, 8'h66, 8'h64, 8'h62, 8'h63};
  logic [2:0] mk [10] = '{3'h7, 3'h0, 3'h1, 3'h1, 3'h7, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0};
  exchange_and_xor_instr_exec exchange_and_xor_instr_exec_inst (.clk_i, .reset_n_i, .instr_valid_i, .opcode_i,
    .operand1_i, .operand2_i, .acc_i, .bank_sel_i, .rd_data_i, .instr_ready_o, .unsupported_o, .done_o,
    .rd_req_o, .rd_addr_o, .rd_indirect_o, .rd_latch_o, .wr_en_o, .wr_addr_o, .wr_indirect_o, .wr_data_o,
    .acc_we_o, .acc_data_o);
  xch_xor_mem_model m (.clk_i, .rd_req_i(rd_req_o), .rd_ind_i(rd_indirect_o), .rd_latch_i(rd_latch_o),
    .wr_en_i(wr_en_o), .wr_ind_i(wr_indirect_o), .rd_addr_i(rd_addr_o), .wr_addr_i(wr_addr_o),
    .wr_data_i(wr_data_o), .rd_data_o(rd_data_i));
  initial forever #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    repeat (16) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  task automatic check(input string nm, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Expectations are taken from the model after the previous write has landed.
  task automatic run(input logic [7:0] op);
    logic [7:0] a, d1, d2, r, p, x, ea, wa, wd;
    logic [1:0] bk;
    logic aw, we, wi;
    int lat, k;
    @(posedge clk_i);
    #1;
    rnd = lfsr(rnd);
    a = rnd[7:0];
    d1 = rnd[16] ? 8'h90 : {1'b0, rnd[14:8]};
    bk = rnd[18:17];
    d2 = rnd[31:24];
    r = {3'h0, bk, op[2:0]};
    p = m.ram[{3'h0, bk, 2'h0, op[0]}];
    x = m.ram[p];
    {aw, we, wi, wa, lat, ea, wd} = {3'b000, d1, 3, a, a};
    casez (op)
      8'b11001???: {aw, we, ea, wa} = {2'b11, m.ram[r], r};
      8'hC5: {aw, we, ea} = {2'b11, m.peek(d1, 0, 0)};
      8'b1100011?: {aw, we, wi, wa, lat, ea} = {3'b111, p, 4, x};
      8'b1101011?: {aw, we, wi, wa, lat, ea, wd} = {3'b111, p, 4, a[7:4], x[3:0], x[7:4], a[3:0]};
      8'b01101???: {aw, ea} = {1'b1, a ^ m.ram[r]};
      8'h65: {aw, ea} = {1'b1, a ^ m.peek(d1, 0, 0)};
      8'b0110011?: {aw, lat, ea} = {1'b1, 4, a ^ x};
      8'h64: {aw, lat, ea} = {1'b1, 2, a ^ d1};
      8'h62: {we, wd} = {1'b1, a ^ m.peek(d1, 0, 1)};
      8'h63: {we, wd} = {1'b1, d2 ^ m.peek(d1, 0, 1)};
      default: lat = 1;
    endcase
    @(posedge clk_i);
    {opcode_i, operand1_i, operand2_i, acc_i, bank_sel_i, instr_valid_i} <= {op, d1, d2, a, bk, 1'b1};
    // The taking edge is the first one counted, so a refusal pulse is seen at k = 1.
    for (k = 1; k < 8; k++) begin
      @(posedge clk_i);
      if (k == 1) instr_valid_i <= 0;
      #1;
      if (done_o === 1'b1 || unsupported_o === 1'b1) break;
    end
    if (k == 8) begin
      n_fail++;
      final_report();
    end
    check("latency", 8'(lat), 8'(k));
    check("refused", {7'h0, lat == 1}, {7'h0, unsupported_o});
    check("acc_we", {7'h0, aw}, {7'h0, acc_we_o});
    if (aw) check("acc_data", ea, acc_data_o);
    check("wr_en", {7'h0, we}, {7'h0, wr_en_o});
    if (we) check("wr_addr", wa, wr_addr_o);
    if (we) check("wr_ind", {7'h0, wi}, {7'h0, wr_indirect_o});
    if (we) check("wr_data", wd, wr_data_o);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1;
    for (int j = 0; j < 10; j++) run(ops[j]);
    run(8'h00);
    run(8'hA5);
    for (int j = 0; j < 300; j++) begin
      rnd = lfsr(rnd);
      run(ops[rnd[3:0] % 10] | {5'h0, rnd[10:8] & mk[rnd[3:0] % 10]});
    end
    final_report();
  end
endmodule // exchange_and_xor_instr_exec_test
`default_nettype wire
